// [core/svw_supervisor.sv]
// supervisor reset core with watchdog, manual debounce and ahb-lite status
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module svw_supervisor #(
  parameter logic [svw_pkg::CNT_W-1:0] WD_SHORT_CYC = svw_pkg::WD_SHORT_CYC,
  parameter logic [svw_pkg::CNT_W-1:0] WD_MID_CYC = svw_pkg::WD_MID_CYC,
  parameter logic [svw_pkg::CNT_W-1:0] WD_LONG_CYC = svw_pkg::WD_LONG_CYC,
  parameter logic [svw_pkg::CNT_W-1:0] RST_PERIOD_CYC = svw_pkg::RST_PERIOD_CYC,
  parameter logic [svw_pkg::CNT_W-1:0] MANUAL_FILTER_CYC = svw_pkg::MANUAL_FILTER_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_n,
  input wire logic [1:0] timeout_select,
  input wire logic threshold_select,
  input wire logic reset_n_in,
  output logic reset_n_out,
  output logic reset_n_oe,
  output logic reset_out,
  output logic threshold_level_sel,
  output logic irq
);
  localparam int unsigned W = svw_pkg::CNT_W;

  svw_pkg::svw_pins_s pins_raw;
  svw_pkg::svw_pins_s pins_s;
  svw_pkg::svw_state_e state;
  svw_pkg::svw_state_e next_state;
  svw_pkg::svw_evt_s status;
  svw_pkg::svw_evt_s mask;
  svw_pkg::svw_evt_s ev_set;
  svw_pkg::svw_evt_s ev_clr;
  svw_pkg::svw_evt_s next_status;
  svw_pkg::svw_view_s view;
  svw_pkg::svw_ahb_s req;
  svw_pkg::svw_ahb_s next_req;

  logic [W-1:0] wd_count;
  logic [W-1:0] next_wd_count;
  logic [W-1:0] rst_count;
  logic [W-1:0] next_rst_count;
  logic [W-1:0] man_count;
  logic [W-1:0] wd_limit;
  logic kick_prev;
  logic kick_fall;
  logic supply_prev;
  logic manual_active;
  logic man_hit;
  logic level_cause;
  logic wd_expire;
  logic next_reset;
  logic addr_ok;
  logic ahb_go;
  logic wr_status;
  logic wr_mask;
  logic [31:0] rd_word;

  function automatic logic [W-1:0] wd_limit_of(input logic [1:0] sel);
    logic [W-1:0] lim;
    lim = WD_MID_CYC;
    unique case (sel)
      svw_pkg::TSEL_GND: lim = WD_SHORT_CYC;
      svw_pkg::TSEL_OPEN: lim = WD_MID_CYC;
      svw_pkg::TSEL_VCC: lim = WD_LONG_CYC;
      // code 11 cannot come from a three-state pad; treat as open
      default: lim = WD_MID_CYC;
    endcase
    return lim;
  endfunction : wd_limit_of

  // ---------------- pin capture ----------------
  assign pins_raw = '{reset_pin: reset_n_in, thr: threshold_select, tsel: timeout_select,
                      kick_n: watchdog_kick_n, manual_n: manual_reset_n,
                      supply_low: supply_low};

  svw_pin_sync #(
    .W(7),
    .RST_VAL(svw_pkg::PINS_IDLE)
  ) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pins_raw),
    .stable(pins_s)
  );

  // ---------------- reset sources ----------------
  // pulses narrower than two clocks may slip past the filter
  assign kick_fall = kick_prev & ~pins_s.kick_n;
  assign man_hit = !pins_s.manual_n && !manual_active
                   && man_count == MANUAL_FILTER_CYC - svw_pkg::CNT_ONE;
  assign level_cause = pins_s.supply_low | manual_active;
  assign wd_limit = wd_limit_of(pins_s.tsel);
  // at or past the limit expires, so a strap change mid-period cannot stall it
  assign wd_expire = state == svw_pkg::MODE_RUN && !kick_fall
                     && wd_count >= wd_limit - svw_pkg::CNT_ONE;

  always_comb begin
    next_state = state;
    unique case (state)
      svw_pkg::MODE_HOLD: begin
        if (!level_cause) next_state = svw_pkg::MODE_DELAY;
      end
      svw_pkg::MODE_DELAY: begin
        if (rst_count == RST_PERIOD_CYC - svw_pkg::CNT_ONE) next_state = svw_pkg::MODE_RUN;
      end
      svw_pkg::MODE_RUN: begin
        if (wd_expire) next_state = svw_pkg::MODE_DELAY;
      end
      default: next_state = svw_pkg::MODE_HOLD;
    endcase
    if (level_cause) next_state = svw_pkg::MODE_HOLD;
  end

  assign next_reset = next_state != svw_pkg::MODE_RUN;
  assign next_rst_count = (state == svw_pkg::MODE_DELAY && next_state == svw_pkg::MODE_DELAY)
                          ? rst_count + svw_pkg::CNT_ONE : '0;
  // count only while running; any reset or kick starts a fresh period
  assign next_wd_count = (state == svw_pkg::MODE_RUN && next_state == svw_pkg::MODE_RUN
                          && !kick_fall) ? wd_count + svw_pkg::CNT_ONE : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      man_count <= '0;
      manual_active <= 1'b0;
    end else if (pins_s.manual_n) begin
      man_count <= '0;
      manual_active <= 1'b0;
    end else if (man_hit) begin
      manual_active <= 1'b1;
    end else if (!manual_active) begin
      man_count <= man_count + svw_pkg::CNT_ONE;
    end
  end

  // power-up starts in the delay state so the first release takes a full period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= svw_pkg::MODE_DELAY;
      rst_count <= '0;
      wd_count <= '0;
      kick_prev <= 1'b1;
      supply_prev <= 1'b0;
    end else begin
      state <= next_state;
      rst_count <= next_rst_count;
      wd_count <= next_wd_count;
      kick_prev <= pins_s.kick_n;
      supply_prev <= pins_s.supply_low;
    end
  end

  // all three reset outputs come from the same next value, so they never disagree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out <= 1'b1;
      reset_n_out <= 1'b0;
      reset_n_oe <= 1'b1;
      threshold_level_sel <= 1'b0;
    end else begin
      reset_out <= next_reset;
      reset_n_out <= ~next_reset;
      reset_n_oe <= next_reset;
      threshold_level_sel <= pins_s.thr;
    end
  end

  // ---------------- ahb-lite slave, zero wait ----------------
  assign addr_ok = haddr[31:4] == 28'h0000000 && haddr[1:0] == 2'h0
                   && hsize == svw_pkg::HSIZE_WORD;
  assign ahb_go = hsel && hready && htrans == svw_pkg::HTRANS_NONSEQ;
  assign next_req = '{valid: ahb_go && addr_ok, write: hwrite, addr: haddr[3:0]};
  assign wr_status = req.valid && req.write && req.addr == svw_pkg::STATUS_OFS;
  assign wr_mask = req.valid && req.write && req.addr == svw_pkg::MASK_OFS;

  assign ev_set = '{wdog: wd_expire, manual: man_hit,
                    supply: pins_s.supply_low & ~supply_prev};
  assign ev_clr = wr_status ? svw_pkg::svw_evt_s'(hwdata[2:0]) : svw_pkg::svw_evt_s'(3'h0);
  // set wins over a write-one clear in the same cycle
  assign next_status = (status & ~ev_clr) | ev_set;

  assign view = '{reset_pin: pins_s.reset_pin, thr: pins_s.thr, tsel: pins_s.tsel,
                  manual: manual_active, supply: pins_s.supply_low,
                  reset: state != svw_pkg::MODE_RUN};
  assign rd_word = (haddr[3:0] == svw_pkg::STATUS_OFS) ? {29'h00000000, status}
                 : (haddr[3:0] == svw_pkg::MASK_OFS) ? {29'h00000000, mask}
                 : (haddr[3:0] == svw_pkg::STATE_OFS) ? {25'h0000000, view}
                 : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      status <= svw_pkg::STATUS_RST;
      mask <= svw_pkg::MASK_RST;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      req <= next_req;
      status <= next_status;
      if (wr_mask) mask <= svw_pkg::svw_evt_s'(hwdata[2:0]);
      hrdata <= (ahb_go && addr_ok && !hwrite) ? rd_word : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(next_status & mask);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wd_period_sel: assert property (
    (state == svw_pkg::MODE_RUN && !level_cause && !kick_fall
     && wd_count == wd_limit_of(pins_s.tsel) - svw_pkg::CNT_ONE)
    |=> state == svw_pkg::MODE_DELAY && status.wdog)
    else $error("watchdog did not expire at the selected period");
  a_kick_restart: assert property (
    (state == svw_pkg::MODE_RUN && kick_fall) |=> wd_count == '0)
    else $error("kick did not restart the watchdog count");
  a_wd_reset_hold: assert property (
    wd_expire |=> reset_out && !reset_n_out && rst_count == '0)
    else $error("watchdog expiry did not start a reset period");
  a_supply_assert: assert property (
    pins_s.supply_low |=> reset_out && !reset_n_out && state == svw_pkg::MODE_HOLD)
    else $error("supply low did not hold reset");
  a_threshold_follow: assert property (
    ##1 threshold_level_sel == $past(pins_s.thr))
    else $error("threshold select not forwarded");
  a_delay_full: assert property (
    $rose(state == svw_pkg::MODE_RUN) |->
      $past(rst_count) == RST_PERIOD_CYC - svw_pkg::CNT_ONE && !reset_out)
    else $error("reset released before a full period");
  a_manual_filter: assert property (
    $rose(manual_active) |-> $past(man_count) == MANUAL_FILTER_CYC - svw_pkg::CNT_ONE
      && $past(!pins_s.manual_n))
    else $error("manual reset taken before the filter time");
  a_manual_assert: assert property (
    manual_active |=> reset_out && !reset_n_out)
    else $error("manual reset did not drive the outputs");
  a_supply_latency: assert property (
    $rose(pins_s.supply_low) |-> ##[1:195] (reset_out && !reset_n_out))
    else $error("supply fail latency exceeded");
  a_manual_release: assert property (
    ($fell(manual_active) && !pins_s.supply_low) |=>
      state == svw_pkg::MODE_DELAY ##1 rst_count == svw_pkg::CNT_ONE)
    else $error("manual release skipped the reset period");
  a_wd_cleared: assert property (
    reset_out |-> wd_count == '0)
    else $error("watchdog counted during reset");
  a_out_complement: assert property (
    reset_out == !reset_n_out && reset_n_oe == reset_out)
    else $error("reset outputs not complementary");
  // the reset-period and filter counters are pinned cycle by cycle, not only at their end points
  a_fresh_period: assert property (
    $fell(reset_out) |-> wd_count == '0)
    else $error("watchdog period did not restart at release");
  a_state_output: assert property (
    reset_out == (state != svw_pkg::MODE_RUN))
    else $error("reset outputs disagree with the internal state");
  a_supply_event: assert property (
    $rose(pins_s.supply_low) |=> status.supply)
    else $error("supply low not recorded in status");
  a_wd_event: assert property (
    wd_expire |=> status.wdog)
    else $error("watchdog expiry not recorded in status");
  a_manual_clear: assert property (
    pins_s.manual_n |=> !manual_active)
    else $error("manual request outlived the button");
  a_tsel_open: assert property (
    pins_s.tsel == 2'h3 |-> wd_limit == WD_MID_CYC)
    else $error("unused timeout code not treated as open");
  a_wd_no_early: assert property (
    (state == svw_pkg::MODE_RUN && !level_cause && wd_count < wd_limit - svw_pkg::CNT_ONE)
    |=> !reset_out)
    else $error("watchdog expired before the selected period");
  a_kick_keeps: assert property (
    (state == svw_pkg::MODE_RUN && kick_fall && !level_cause) |=> !reset_out)
    else $error("kick did not keep the processor running");
  a_delay_count: assert property (
    (state == svw_pkg::MODE_DELAY && !level_cause
     && rst_count != RST_PERIOD_CYC - svw_pkg::CNT_ONE)
    |=> state == svw_pkg::MODE_DELAY && rst_count == $past(rst_count) + svw_pkg::CNT_ONE)
    else $error("reset period counter skipped");
  a_filter_count: assert property (
    (!pins_s.manual_n && !manual_active && !man_hit)
    |=> man_count == $past(man_count) + svw_pkg::CNT_ONE)
    else $error("manual filter counter skipped");

  c_wd_expire: cover property (state == svw_pkg::MODE_RUN ##1 wd_expire);
  c_kick_seen: cover property (state == svw_pkg::MODE_RUN && kick_fall);
  c_manual_taken: cover property ($rose(manual_active));
  c_supply_cycle: cover property ($rose(pins_s.supply_low) ##[1:50] !pins_s.supply_low);
  c_irq_raised: cover property ($rose(irq));
endmodule : svw_supervisor
`default_nettype wire

// [core/svw_pkg.sv]
// constants, types and timing for the supervisor watchdog reset block
package svw_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CNT_W = 25;
  localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;

  localparam int unsigned WD_SHORT_MS = 150;
  localparam int unsigned WD_MID_MS = 600;
  localparam int unsigned WD_LONG_MS = 1200;
  localparam int unsigned RST_PERIOD_MS = 610;
  localparam int unsigned MANUAL_FILTER_MS = 10;
  localparam int unsigned SUPPLY_FAIL_US = 8;

  localparam logic [CNT_W-1:0] WD_SHORT_CYC = CNT_W'(WD_SHORT_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WD_MID_CYC = CNT_W'(WD_MID_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WD_LONG_CYC = CNT_W'(WD_LONG_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_PERIOD_CYC = CNT_W'(RST_PERIOD_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] MANUAL_FILTER_CYC = CNT_W'(MANUAL_FILTER_MS * CYC_PER_MS);
  localparam int unsigned SUPPLY_FAIL_CYC = (SUPPLY_FAIL_US * 1000) / CLK_NS;

  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] MASK_OFS = 4'h4;
  localparam logic [3:0] STATE_OFS = 4'h8;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [6:0] PINS_IDLE = 7'h46;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_DELAY = 2'b01,
    MODE_RUN = 2'b10
  } svw_state_e;

  typedef enum logic [1:0] {
    TSEL_GND = 2'b00,
    TSEL_OPEN = 2'b01,
    TSEL_VCC = 2'b10
  } svw_tsel_e;

  // event bits: status and mask share this layout
  typedef struct packed {
    logic wdog;
    logic manual;
    logic supply;
  } svw_evt_s;

  typedef struct packed {
    logic reset_pin;
    logic thr;
    logic [1:0] tsel;
    logic kick_n;
    logic manual_n;
    logic supply_low;
  } svw_pins_s;

  typedef struct packed {
    logic reset_pin;
    logic thr;
    logic [1:0] tsel;
    logic manual;
    logic supply;
    logic reset;
  } svw_view_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] addr;
  } svw_ahb_s;
endpackage : svw_pkg

// [core/svw_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module svw_pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] stable
);
  logic [W-1:0] meta;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic [W-1:0] next_stable;

  // a bit changes only once stages two and three agree
  assign next_stable = (sync2 & sync3) | (stable & (sync2 ^ sync3));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= RST_VAL;
      sync2 <= RST_VAL;
      sync3 <= RST_VAL;
      stable <= RST_VAL;
    end else begin
      meta <= pin_in;
      sync2 <= meta;
      sync3 <= sync2;
      stable <= next_stable;
    end
  end
endmodule : svw_pin_sync
`default_nettype wire

// [tb/svw_cpu_model.sv]
// processor model: kicks the watchdog and sits in reset while the reset wire is low
`timescale 1ns/1ps
`default_nettype none
module svw_cpu_model (
  input wire logic hclk,
  input wire logic reset_wire_n,
  input wire logic kick_en,
  input wire logic [7:0] kick_period,
  output logic watchdog_kick_n
);
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    watchdog_kick_n = 1'h1;
  end
  // a processor held in reset runs no code, so it cannot kick
  always @(posedge hclk) begin
    if (!reset_wire_n || !kick_en) begin
      cnt <= 8'h00;
      watchdog_kick_n <= 1'h1;
    end else begin
      cnt <= (cnt >= kick_period) ? 8'h00 : cnt + 8'h01;
      // two cycles low: short pulses may fall between the sync flops
      watchdog_kick_n <= (cnt >= 8'h02);
    end
  end
endmodule : svw_cpu_model
`default_nettype wire

// [tb/svw_supervisor_tb.sv]
// self-checking bench for the supervisor reset core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module svw_supervisor_tb;
  localparam int RP = 50;
  localparam int FLT = 20;
  // expected watchdog limits per select code, code 0 in the low byte
  localparam logic [31:0] LIM = {8'h50, 8'h78, 8'h50, 8'h28};
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] got_e;
  logic [1:0] htrans = 2'h0;
  logic [1:0] tsel = 2'h0;
  logic supply_low = 1'h0;
  logic manual_n = 1'h1;
  logic thr = 1'h0;
  logic kick_en = 1'h1;
  logic rd_ph = 1'h0;
  logic hreadyout, hresp, kick_n, reset_n_out, reset_n_oe, reset_out, thr_out, irq, wire_n;
  logic [7:0] kick_per = 8'h14;
  logic [31:0] rnd = 32'h18F7343D;
  logic [31:0] exp_q [$];
  int mismatches = 0;
  int total_checks = 0;
  int n;
  always #20 hclk = ~hclk;
  // open-drain reset wire with its pull-up
  assign wire_n = reset_n_oe ? 1'h0 : 1'h1;
  svw_supervisor #(.WD_SHORT_CYC(25'h28), .WD_MID_CYC(25'h50), .WD_LONG_CYC(25'h78),
    .RST_PERIOD_CYC(25'h32), .MANUAL_FILTER_CYC(25'h14)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(svw_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .supply_low(supply_low),
    .manual_reset_n(manual_n), .watchdog_kick_n(kick_n), .timeout_select(tsel),
    .threshold_select(thr), .reset_n_in(wire_n), .reset_n_out(reset_n_out),
    .reset_n_oe(reset_n_oe), .reset_out(reset_out), .threshold_level_sel(thr_out), .irq(irq));
  svw_cpu_model cpu (.hclk(hclk), .reset_wire_n(wire_n), .kick_en(kick_en),
    .kick_period(kick_per), .watchdog_kick_n(kick_n));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int c);
    repeat (c) @(posedge hclk);
  endtask : tick
  // counts edges until reset_out, sampled at the edge, reaches v
  task automatic wait_rst(input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge hclk);
      cnt++;
    end while (reset_out !== v && cnt < 400);
    if (cnt >= 400) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_rst
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= svw_pkg::HTRANS_NONSEQ;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'h1 && k < 20);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    rd_ph <= !w;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'h1 && k < 40);
    rd_ph <= 1'h0;
    if (k >= 40) begin
      mismatches++;
      report_and_stop();
    end
  endtask : bus
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'h0, 32'h0);
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask : wr
  // read data is taken at the edge that closes the data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) begin
      got_e = exp_q.pop_front();
      `CHK(hrdata, got_e)
      `CHK(hresp, 1'h0)
    end
    if (hresetn) begin
      `CHK(reset_n_out, ~reset_out)
      `CHK(reset_n_oe, reset_out)
    end
  end
  initial begin
    tick(3);
    hresetn <= 1'h1;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    rd(32'hC, 32'h0);
    rd(32'h10, 32'h0);
    wait_rst(1'h0, n);
    $display("test power-on done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      kick_per <= 8'(8 + rnd[4:0] % 20);
      repeat (60) begin
        @(posedge hclk);
        `CHK(reset_out, 1'h0)
      end
    end
    $display("test kicking done");
    kick_en <= 1'h0;
    wait_rst(1'h1, n);
    for (int c = 0; c < 4; c++) begin
      tsel <= c[1:0];
      wait_rst(1'h0, n);
      `CHK(n, RP)
      wait_rst(1'h1, n);
      `CHK(n, LIM[c*8 +: 8])
    end
    kick_en <= 1'h1;
    tsel <= 2'h0;
    wait_rst(1'h0, n);
    rd(32'h0, 32'h4);
    `CHK(irq, 1'h0)
    rnd = lfsr(rnd);
    wr(32'h4, rnd);
    rd(32'h4, {29'h0, rnd[2:0]});
    wr(32'h4, 32'h7);
    tick(2);
    `CHK(irq, 1'h1)
    wr(32'h0, 32'h7);
    tick(2);
    `CHK(irq, 1'h0)
    rd(32'h0, 32'h0);
    $display("test watchdog done");
    supply_low <= 1'h1;
    wait_rst(1'h1, n);
    `CHK(n <= svw_pkg::SUPPLY_FAIL_CYC, 1'h1)
    rnd = lfsr(rnd);
    tick(20 + rnd[5:0]);
    rd(32'h8, 32'h3);
    rd(32'h0, 32'h1);
    `CHK(irq, 1'h1)
    supply_low <= 1'h0;
    wait_rst(1'h0, n);
    `CHK(n >= RP && n <= RP + 8, 1'h1)
    wr(32'h0, 32'h7);
    $display("test supply done");
    manual_n <= 1'h0;
    tick(FLT / 2);
    manual_n <= 1'h1;
    repeat (60) begin
      @(posedge hclk);
      `CHK(reset_out, 1'h0)
    end
    manual_n <= 1'h0;
    wait_rst(1'h1, n);
    `CHK(n >= FLT && n <= FLT + 8, 1'h1)
    tick(10);
    rd(32'h0, 32'h2);
    manual_n <= 1'h1;
    wait_rst(1'h0, n);
    `CHK(n >= RP && n <= RP + 8, 1'h1)
    wr(32'h0, 32'h7);
    $display("test manual done");
    thr <= 1'h1;
    tsel <= 2'h1;
    tick(8);
    `CHK(thr_out, 1'h1)
    rd(32'h8, 32'h68);
    thr <= 1'h0;
    tick(8);
    `CHK(thr_out, 1'h0)
    $display("test threshold done");
    hresetn <= 1'h0;
    tick(2);
    `CHK(reset_out, 1'h1)
    hresetn <= 1'h1;
    wait_rst(1'h0, n);
    `CHK(n, RP + 1)
    $display("test second reset done");
    report_and_stop();
  end
endmodule : svw_supervisor_tb
`default_nettype wire
